// *** logic/smc_standby_ctrl.sv ***
// Standby mode controller: halt, deep halt, sleep, wake, test high impedance and debug clocking
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module smc_standby_ctrl
	import smc_pkg::*;
#(
	parameter int SETTLE_CYC_MAX = SMC_SETTLE_CYC
)
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// AXI4-Lite write channels
	input wire logic [31:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read channels
	input wire logic [31:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	// Core CPU side
	input wire logic halt_exec_in,
	input wire logic sleep_exec_in,
	input wire logic interrupt_accept_flag_in,
	input wire logic irq_level_ok_in,
	input wire logic debug_mode_in,
	input wire logic area2_access_in,
	output logic cpu_run_out,
	output logic trap_request_out,
	output logic area2_allow_out,
	// Interrupt sources
	input wire logic nmi_in,
	input wire logic irq_periph_in,
	input wire logic irq_clock_timer_in,
	input wire logic irq_external_in,
	// Bus control unit
	input wire logic bus_cycle_busy_in,
	output logic bus_ctrl_run_out,
	output logic chip_enable_block_out,
	output logic bus_clock_en_out,
	output logic dram_refresh_en_out,
	output logic dma_run_out,
	// Clocks and peripherals
	output logic fast_osc_en_out,
	output logic slow_osc_en_out,
	output logic clock_timer_run_out,
	output logic periph_run_out,
	output logic cpu_clk_fast_sel_out,
	output logic state_hold_out,
	// Test pins, sampled from outside
	input wire logic test_mode_input_a_in,
	input wire logic test_mode_input_b_in,
	input wire logic test_mode_hiz_input_in,
	input wire logic reset_pin_n_in,
	output logic pin_hiz_out,
	output logic pullup_en_out
);
	import smc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic hiz_prev_q;
	logic hiz_mode_q;
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pin_s1_q <= 4'hF;
			pin_s2_q <= 4'hF;
		end
		else
		begin
			pin_s1_q <= {reset_pin_n_in, test_mode_hiz_input_in, test_mode_input_b_in, test_mode_input_a_in};
			pin_s2_q <= pin_s1_q;
		end
	end
	wire reset_pin_n_s = pin_s2_q[3];
	wire hiz_s = pin_s2_q[2];
	// Falling edge of the hiz input while reset pin low arms the float
	wire hiz_fall = hiz_prev_q & ~hiz_s;
	wire hiz_d = ~reset_pin_n_s & ~hiz_s & (hiz_mode_q | hiz_fall);
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hiz_prev_q <= 1'b1;
			hiz_mode_q <= 1'b0;
		end
		else
		begin
			hiz_prev_q <= hiz_s;
			hiz_mode_q <= hiz_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] clk_opt_q;
	logic [31:0] settle_cyc_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic wake_pend_q;
	logic trap_q;
	logic [31:0] settle_cnt_q;
	smc_state_t state_q;
	smc_state_t state_d;

	function automatic logic addr_is(input logic [31:0] a, input logic [19:0] r);
		addr_is = (a[31:20] == 12'h000) && (a[19:2] == r[19:2]);
	endfunction : addr_is

	// Standby states in which the CPU is stopped; SMC_DRAIN also stops it but is not counted here
	function automatic logic is_standby(input smc_state_t s);
		is_standby = (s == SMC_HALT) || (s == SMC_DEEP) || (s == SMC_SLEEP) || (s == SMC_SETTLE);
	endfunction : is_standby

	// States that stop the bus clock, refresh and DMA
	function automatic logic is_bus_stop(input smc_state_t s);
		is_bus_stop = (s == SMC_DEEP) || (s == SMC_SLEEP) || (s == SMC_SETTLE);
	endfunction : is_bus_stop

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: write taken when address and data are both present
	wire wr_fire = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_q;
	wire wr_opt = addr_is(s_axi_awaddr_in, SMC_ADDR_CLK_OPT);
	wire wr_dly = addr_is(s_axi_awaddr_in, SMC_ADDR_WAKE_DLY);
	wire wr_ok = wr_opt | wr_dly | addr_is(s_axi_awaddr_in, SMC_ADDR_STATUS);
	wire rd_fire = s_axi_arvalid_in & ~rvalid_q;
	wire rd_opt = addr_is(s_axi_araddr_in, SMC_ADDR_CLK_OPT);
	wire rd_dly = addr_is(s_axi_araddr_in, SMC_ADDR_WAKE_DLY);
	wire rd_sts = addr_is(s_axi_araddr_in, SMC_ADDR_STATUS);
	wire [31:0] status_word = {24'h000000, wake_pend_q, hiz_mode_q, debug_mode_in, 2'b00, state_q};
	wire [31:0] rd_mux = rd_opt ? {24'h000000, clk_opt_q} : rd_dly ? settle_cyc_q : rd_sts ? status_word : 32'h0;
	assign s_axi_awready_out = wr_fire;
	assign s_axi_wready_out = wr_fire;
	assign s_axi_arready_out = rd_fire;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rresp_out = rresp_q;
	assign s_axi_rdata_out = rdata_q;

	// Clock option register: only the deep-halt select bit is kept
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			clk_opt_q <= SMC_CLK_OPT_RST;
		else if (wr_fire && wr_opt && s_axi_wstrb_in[0])
			clk_opt_q <= s_axi_wdata_in[7:0] & SMC_CLK_OPT_MASK;
	end

	// Settle interval in clock cycles, written byte by byte
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			settle_cyc_q <= 32'h0;
		else if (wr_fire && wr_dly)
		begin
			for (int i = 0; i < 4; i++)
				if (s_axi_wstrb_in[i])
					settle_cyc_q[i*8 +: 8] <= s_axi_wdata_in[i*8 +: 8];
		end
	end

	// Write response stands until the master takes it
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= SMC_AXI_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_ok ? SMC_AXI_OKAY : SMC_AXI_SLVERR;
		end
		else if (s_axi_bready_in)
			bvalid_q <= 1'b0;
	end

	// Read data and response stand until the master takes them
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= SMC_AXI_OKAY;
			rdata_q <= 32'h0;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= (rd_opt | rd_dly | rd_sts) ? SMC_AXI_OKAY : SMC_AXI_SLVERR;
			rdata_q <= rd_mux;
		end
		else if (s_axi_rready_in)
			rvalid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Wake qualification
	wire accept_ok = interrupt_accept_flag_in & irq_level_ok_in;
	wire halt_wake = nmi_in | (accept_ok & (irq_periph_in | irq_clock_timer_in | irq_external_in));
	wire sleep_wake = nmi_in | (accept_ok & (irq_clock_timer_in | irq_external_in));
	wire deep_sel = clk_opt_q[SMC_BIT_DEEP_HALT_SEL];
	logic sleep_req_q;
	wire [31:0] settle_lim = (settle_cyc_q > SETTLE_CYC_MAX) ? 32'(SETTLE_CYC_MAX) : settle_cyc_q;
	wire settle_done = settle_cnt_q >= settle_lim;
	wire pend_wake = sleep_req_q ? sleep_wake : halt_wake;

	////////////////////////////////////////////////////////////////////////////
	// Standby state machine
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			SMC_RUN:
				if (halt_exec_in | sleep_exec_in)
					state_d = SMC_DRAIN;
			SMC_DRAIN:
				if (!bus_cycle_busy_in)
					state_d = sleep_req_q ? SMC_SLEEP : deep_sel ? SMC_DEEP : SMC_HALT;
			SMC_HALT:
				if (halt_wake | wake_pend_q)
					state_d = SMC_RUN;
			SMC_DEEP:
				if (halt_wake | wake_pend_q)
					state_d = SMC_RUN;
			SMC_SLEEP:
				if (sleep_wake | wake_pend_q)
					state_d = SMC_SETTLE;
			SMC_SETTLE:
				if (settle_done)
					state_d = SMC_RUN;
			default:
				state_d = SMC_RUN;
		endcase
	end

	wire wake_edge = is_standby(state_q) && (state_q != SMC_SETTLE) && (state_d != state_q);
	wire settle_exit = (state_q == SMC_SETTLE) && settle_done;

	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			state_q <= SMC_RUN;
		else
			state_q <= state_d;
	end

	// Sleep or halt is remembered from the instruction that began standby
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			sleep_req_q <= 1'b0;
		else if (state_q == SMC_RUN)
			sleep_req_q <= sleep_exec_in & ~halt_exec_in;
	end

	// Wake seen while the bus drains is kept until standby is reached
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			wake_pend_q <= 1'b0;
		else if (state_q == SMC_DRAIN && pend_wake)
			wake_pend_q <= 1'b1;
		else if (state_q != SMC_DRAIN)
			wake_pend_q <= 1'b0;
	end

	// One-cycle trap request as the CPU restarts
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			trap_q <= 1'b0;
		else
			trap_q <= (wake_edge && state_d == SMC_RUN) | settle_exit;
	end

	// Settle counter runs only while waiting for the fast oscillator
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			settle_cnt_q <= 32'h0;
		else
			settle_cnt_q <= (state_q == SMC_SETTLE) ? settle_cnt_q + 32'h1 : 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock, bus and pin controls
	wire in_sleep = state_q == SMC_SLEEP;
	wire standby = is_standby(state_q);
	wire bus_stop = is_bus_stop(state_q);
	assign cpu_run_out = (state_q == SMC_RUN);
	assign trap_request_out = trap_q;
	assign area2_allow_out = debug_mode_in & area2_access_in;
	assign bus_ctrl_run_out = ~bus_stop & ~hiz_mode_q;
	assign chip_enable_block_out = standby;
	assign bus_clock_en_out = ~bus_stop;
	assign dram_refresh_en_out = ~bus_stop & ~debug_mode_in;
	assign dma_run_out = ~bus_stop & ~debug_mode_in;
	assign fast_osc_en_out = ~in_sleep & ~hiz_mode_q;
	assign slow_osc_en_out = ~hiz_mode_q;
	assign clock_timer_run_out = ~debug_mode_in;
	assign periph_run_out = ~in_sleep & ~(state_q == SMC_SETTLE) & ~debug_mode_in;
	// CPU runs from the fast oscillator whenever it runs outside high impedance mode, so sleep exit resumes on it
	assign cpu_clk_fast_sel_out = ~in_sleep & ~hiz_mode_q;
	assign state_hold_out = standby;
	assign pin_hiz_out = hiz_mode_q;
	assign pullup_en_out = ~hiz_mode_q;
endmodule : smc_standby_ctrl

// *** logic/smc_pkg.sv ***
// Package: register map, field positions and timing constants of the standby mode control
package smc_pkg;
	localparam logic [19:0] SMC_ADDR_CLK_OPT = 20'h40150;
	localparam logic [19:0] SMC_ADDR_WAKE_DLY = 20'h40154;
	localparam logic [19:0] SMC_ADDR_STATUS = 20'h40158;
	localparam int SMC_BIT_DEEP_HALT_SEL = 3;
	localparam logic [7:0] SMC_CLK_OPT_RST = 8'h00;
	localparam logic [7:0] SMC_CLK_OPT_MASK = 8'h08;
	localparam int SMC_CLK_HZ = 200_000_000;
	localparam int SMC_SETTLE_MS = 10;
	localparam int SMC_SETTLE_CYC = SMC_SETTLE_MS * (SMC_CLK_HZ / 1000);
	localparam logic [1:0] SMC_AXI_OKAY = 2'h0;
	localparam logic [1:0] SMC_AXI_SLVERR = 2'h2;
	typedef enum logic [2:0]
	{
		SMC_RUN = 3'b000,
		SMC_DRAIN = 3'b001,
		SMC_HALT = 3'b010,
		SMC_DEEP = 3'b011,
		SMC_SLEEP = 3'b100,
		SMC_SETTLE = 3'b101
	} smc_state_t;
endpackage : smc_pkg

// *** verification/smc_sva.sv ***
// Port checker for the standby mode controller
`timescale 1ns/10ps
module smc_sva
(
	// Watched ports
	input wire logic clk_sys_in, rst_in, halt_exec_in, sleep_exec_in, nmi_in, irq_clock_timer_in, irq_external_in,
	input wire logic debug_mode_in, area2_access_in, cpu_run_out, trap_request_out, area2_allow_out, pin_hiz_out,
	input wire logic chip_enable_block_out, bus_clock_en_out, dram_refresh_en_out, dma_run_out, fast_osc_en_out,
	input wire logic slow_osc_en_out, clock_timer_run_out, periph_run_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire sleep_w = !fast_osc_en_out && !pin_hiz_out;
	wire wake_w = nmi_in || irq_clock_timer_in || irq_external_in;
	a_area2_gate: assert property (area2_allow_out == (debug_mode_in && area2_access_in))
		else $error("area2 gate");
	a_standby_entry: assert property (cpu_run_out && (halt_exec_in || sleep_exec_in) |=> !cpu_run_out)
		else $error("standby not entered");
	a_bus_clock_stop: assert property (!bus_clock_en_out |-> !dma_run_out && !dram_refresh_en_out)
		else $error("dma or refresh without bus clock");
	a_sleep_clocks: assert property (sleep_w |-> slow_osc_en_out && clock_timer_run_out && !periph_run_out)
		else $error("sleep clocks");
	a_run_open: assert property (cpu_run_out |-> !chip_enable_block_out && bus_clock_en_out)
		else $error("bus closed while running");
	a_trap_wake: assert property ($rose(cpu_run_out) |-> trap_request_out)
		else $error("wake without trap");
	a_trap_pulse: assert property (trap_request_out |=> !trap_request_out)
		else $error("trap too long");
	a_sleep_hold: assert property (sleep_w && $past(sleep_w) && !wake_w |=> sleep_w)
		else $error("sleep left without source");
	c_halt: cover property (cpu_run_out ##1 !cpu_run_out && bus_clock_en_out);
	c_sleep: cover property (sleep_w ##1 !sleep_w);
	c_trap: cover property (trap_request_out);
endmodule : smc_sva
bind smc_standby_ctrl smc_sva u_sva (.*);

// *** verification/smc_bus_model.sv ***
// Bus control unit and test pin model beside the standby controller
`timescale 1ns/10ps
module smc_bus_model
(
	// Clock
	input wire logic clk_sys_in,
	// High impedance test request from the bench
	input wire logic hiz_req_in,
	// Bus cycle and pins
	output logic busy_out,
	output logic test_a_out,
	output logic test_b_out,
	output logic test_hiz_out,
	output logic reset_pin_n_out
);
	logic [2:0] left_q = 3'h0;
	// Test inputs idle high; a request pulls the reset pin low, then the hiz input
	assign test_a_out = 1'b1;
	assign test_b_out = 1'b1;
	initial
	begin
		busy_out = 1'b0;
		test_hiz_out = 1'b1;
		reset_pin_n_out = 1'b1;
	end
	// Bus cycles of random length
	always @(posedge clk_sys_in)
	begin
		left_q <= left_q + 3'($urandom_range(2, 1));
		busy_out <= left_q[2];
		reset_pin_n_out <= !hiz_req_in;
		test_hiz_out <= !(hiz_req_in && !reset_pin_n_out);
	end
endmodule : smc_bus_model

// *** verification/testbench.sv ***
// Self-checking bench of the standby mode controller
`timescale 1ns/10ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("wrong value %0t %h %h", $time, a, b); end end
`define WT(c) begin n = 0; do @(posedge clk_sys_in); while (!(c) && ++n < 200); if (n >= 200) finish_test(1); end
module testbench;
	import smc_pkg::*;
	localparam int SETTLE = 20;
	localparam logic [31:0] OPT = {12'h000, SMC_ADDR_CLK_OPT};
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hF;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, halt_exec_in, sleep_exec_in;
	logic interrupt_accept_flag_in, irq_level_ok_in, debug_mode_in, area2_access_in, cpu_run_out, trap_request_out;
	logic area2_allow_out, nmi_in, irq_periph_in, irq_clock_timer_in, irq_external_in, bus_cycle_busy_in;
	logic bus_ctrl_run_out, chip_enable_block_out, bus_clock_en_out, dram_refresh_en_out, dma_run_out;
	logic fast_osc_en_out, slow_osc_en_out, clock_timer_run_out, periph_run_out, cpu_clk_fast_sel_out;
	logic state_hold_out, test_mode_input_a_in, test_mode_input_b_in, test_mode_hiz_input_in, reset_pin_n_in;
	logic pin_hiz_out, pullup_en_out;
	logic hiz_req = 1'b0;
	int err_count = 0;
	int checked = 0;
	int n;
	smc_standby_ctrl #(.SETTLE_CYC_MAX(50)) dut (.*);
	smc_bus_model u_bus (.clk_sys_in, .hiz_req_in(hiz_req), .busy_out(bus_cycle_busy_in), .test_a_out(test_mode_input_a_in),
		.test_b_out(test_mode_input_b_in), .test_hiz_out(test_mode_hiz_input_in), .reset_pin_n_out(reset_pin_n_in));
	always #2.5 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////
	function automatic logic wake_ok(input logic slp, input int src, input logic ie);
		return src == 0 || (ie && !(slp && src == 1));
	endfunction : wake_ok
	task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] r);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
		`WT(s_axi_awready_out)
		{s_axi_awvalid_in, s_axi_wvalid_in} <= 2'h0;
		`WT(s_axi_bvalid_out)
		s_axi_bready_in <= 1'b0;
		`CK(s_axi_bresp_out, r)
		@(posedge clk_sys_in);
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a, d, input logic [1:0] r);
		s_axi_araddr_in <= a;
		{s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
		`WT(s_axi_arready_out)
		s_axi_arvalid_in <= 1'b0;
		`WT(s_axi_rvalid_out)
		s_axi_rready_in <= 1'b0;
		`CK({s_axi_rdata_out, s_axi_rresp_out}, {d, r})
		@(posedge clk_sys_in);
	endtask : axi_rd
	task automatic standby(input logic slp, deep, input int src, input logic ie);
		logic on;
		on = !(slp || deep);
		{interrupt_accept_flag_in, irq_level_ok_in} <= {ie, 1'b1};
		{halt_exec_in, sleep_exec_in} <= {!slp, slp};
		@(posedge clk_sys_in);
		{halt_exec_in, sleep_exec_in} <= 2'h0;
		`WT(!bus_cycle_busy_in)
		@(posedge clk_sys_in);
		`CK({cpu_run_out, bus_clock_en_out, dma_run_out, dram_refresh_en_out}, {1'b0, on, on, on})
		`CK({fast_osc_en_out, periph_run_out, slow_osc_en_out, clock_timer_run_out}, {!slp, !slp, 2'h3})
		`CK(chip_enable_block_out, 1'b1)
		{nmi_in, irq_periph_in, irq_clock_timer_in, irq_external_in} <= 4'h8 >> src;
		if (!wake_ok(slp, src, ie))
		begin
			repeat (10) @(posedge clk_sys_in);
			`CK(cpu_run_out, 1'b0)
			nmi_in <= 1'b1;
		end
		`WT(cpu_run_out)
		`CK(trap_request_out, 1'b1)
		`CK(slp ? (n >= SETTLE && n <= SETTLE + 3) : n == 1, 1'b1)
		`CK({fast_osc_en_out, cpu_clk_fast_sel_out}, 2'h3)
		{nmi_in, irq_periph_in, irq_clock_timer_in, irq_external_in} <= 4'h0;
		@(posedge clk_sys_in);
	endtask : standby
	task automatic finish_test(input int bad);
		err_count += bad;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////
	initial
	begin
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		{halt_exec_in, sleep_exec_in, interrupt_accept_flag_in, irq_level_ok_in, debug_mode_in} = '0;
		{area2_access_in, nmi_in, irq_periph_in, irq_clock_timer_in, irq_external_in} = '0;
		{s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = '0;
		n = $urandom(32'hAA103F56);
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		axi_rd(OPT, {24'h0, SMC_CLK_OPT_RST}, SMC_AXI_OKAY);
		axi_wr(OPT, 32'hFFFFFFFF, SMC_AXI_OKAY);
		axi_rd(OPT, {24'h0, SMC_CLK_OPT_MASK}, SMC_AXI_OKAY);
		axi_wr(32'h00040160, 32'h0, SMC_AXI_SLVERR);
		axi_rd(32'h00040160, 32'h0, SMC_AXI_SLVERR);
		axi_wr({12'h000, SMC_ADDR_WAKE_DLY}, SETTLE, SMC_AXI_OKAY);
		$display("test registers done");
		// Every wake source in basic halt, deep halt and sleep
		for (int k = 0; k < 12; k++)
		begin
			axi_wr(OPT, {28'h0, k % 3 == 1, 3'h0}, SMC_AXI_OKAY);
			standby(k % 3 == 2, k % 3 == 1, k / 3, (k == 4) ? 1'b0 : 1'($urandom_range(1, 0)));
			$display("test standby %0d done", k);
		end
		debug_mode_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		`CK({periph_run_out, bus_ctrl_run_out, fast_osc_en_out, cpu_clk_fast_sel_out}, 4'h7)
		repeat (16)
		begin
			{debug_mode_in, area2_access_in} <= 2'($urandom_range(3, 0));
			@(posedge clk_sys_in);
			`CK(area2_allow_out, debug_mode_in && area2_access_in)
		end
		$display("test debug done");
		hiz_req <= 1'b1;
		repeat (8) @(posedge clk_sys_in);
		`CK({pin_hiz_out, pullup_en_out, fast_osc_en_out, slow_osc_en_out}, 4'h8)
		hiz_req <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		`CK({pin_hiz_out, pullup_en_out}, 2'h1)
		$display("test hiz done");
		finish_test(0);
	end
endmodule : testbench
